/* pbp_pkg.sv */
/*
  Shared constants for the biphase mark coded configuration channel link:
  clock rate, bit timing and decoder thresholds.
  Assumes a single 40 MHz core clock at both ends of the link.
*/
`default_nettype none

package pbp_pkg;

  // core clock period
  localparam int CLK_PERIOD_NS = 25;
  // nominal unit interval on the wire
  localparam int BIT_TIME_NS = 3300;
  localparam int CNT_W = 9;
  // half a unit interval in clock cycles, rounded down
  localparam logic [CNT_W-1:0] HALF_CYC = CNT_W'(BIT_TIME_NS / 2 / CLK_PERIOD_NS);
  // intervals below this decode as a half bit
  localparam logic [CNT_W-1:0] SHORT_MAX = CNT_W'(3 * BIT_TIME_NS / 4 / CLK_PERIOD_NS);
  // intervals below this (and not short) decode as a full bit
  localparam logic [CNT_W-1:0] LONG_MAX = CNT_W'(5 * BIT_TIME_NS / 4 / CLK_PERIOD_NS);
  // no edge for this long means the bus is idle
  localparam logic [CNT_W-1:0] IDLE_CYC = CNT_W'(3 * BIT_TIME_NS / CLK_PERIOD_NS);
  // line reset level and transmitter start level
  localparam logic LINE_RST = 1'b0;

  typedef enum logic [1:0] {
    PBP_TX_IDLE,
    PBP_TX_BIT,
    PBP_TX_CLOSE
  } pbp_tx_e;

endpackage : pbp_pkg

`default_nettype wire

/* pbp_cc_if.sv */
/*
  The shared configuration channel wire pair of one port and the partner plug.
  The testbench drives plug_flip to pick which receptacle pin the plug mates with;
  an undriven pin reads low, standing for the idle DC bias.
*/
`timescale 1ns/10ps
`default_nettype none

interface pbp_cc_if;
  // device drive, per pin
  logic config_channel_pin_one_out;
  logic config_channel_pin_one_oe;
  logic config_channel_pin_two_out;
  logic config_channel_pin_two_oe;
  // partner drive on its single wire
  logic partner_cc_out;
  logic partner_cc_oe;
  // plug orientation, 1 = partner mates with pin two
  logic plug_flip;
  // resolved levels
  logic config_channel_pin_one;
  logic config_channel_pin_two;
  logic partner_cc;

  logic dev_on_wire_oe;
  logic dev_on_wire_out;

  assign dev_on_wire_oe = plug_flip ? config_channel_pin_two_oe : config_channel_pin_one_oe;
  assign dev_on_wire_out = plug_flip ? config_channel_pin_two_out : config_channel_pin_one_out;
  assign partner_cc = dev_on_wire_oe ? dev_on_wire_out : (partner_cc_oe & partner_cc_out);
  assign config_channel_pin_one = config_channel_pin_one_oe ? config_channel_pin_one_out :
                                  (!plug_flip & partner_cc_oe & partner_cc_out);
  assign config_channel_pin_two = config_channel_pin_two_oe ? config_channel_pin_two_out :
                                  (plug_flip & partner_cc_oe & partner_cc_out);

  modport device (
    input config_channel_pin_one,
    input config_channel_pin_two,
    output config_channel_pin_one_out,
    output config_channel_pin_one_oe,
    output config_channel_pin_two_out,
    output config_channel_pin_two_oe
  );

  modport partner (
    input partner_cc,
    output partner_cc_out,
    output partner_cc_oe
  );
endinterface : pbp_cc_if

`default_nettype wire

/* pbp_device_end.sv */
/*
  Device end of the configuration channel physical layer: a biphase mark
  encoder/decoder core plus the pin selection for the port's two CC pins.
  Assumes attach and orientation come from the plug detection logic and that
  the user feeds preamble, payload and end-of-packet bits itself.
*/
`timescale 1ns/10ps
`default_nettype none

module pbp_bmc_core (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic enable_in,
  // transmit bit stream
  input wire logic tx_valid_in,
  input wire logic tx_bit_in,
  input wire logic tx_last_in,
  output logic tx_ready_out,
  output logic tx_busy_out,
  // line
  input wire logic line_in,
  output logic line_out,
  output logic line_oe_out,
  // receive bit stream
  output logic rx_valid_out,
  output logic rx_bit_out,
  output logic bus_active_out
);
  pbp_pkg::pbp_tx_e st_reg, st_next;
  logic [pbp_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic level_reg, level_next;
  logic oe_reg, oe_next;
  logic half_reg, half_next;
  logic bit_reg, bit_next;
  logic last_reg, last_next;
  logic half_done;
  logic load_more;
  logic prev_reg, prev_next;
  logic [pbp_pkg::CNT_W-1:0] ivl_reg, ivl_next;
  logic pend_reg, pend_next;
  logic rxv_reg, rxv_next;
  logic rxb_reg, rxb_next;
  logic act_reg, act_next;
  logic edge_seen;
  assign half_done = (cnt_reg == pbp_pkg::HALF_CYC - 1'b1);
  assign load_more = (st_reg == pbp_pkg::PBP_TX_BIT) && half_reg && half_done && !last_reg &&
                     tx_valid_in;
  // start only on an idle bus
  assign tx_ready_out = ((st_reg == pbp_pkg::PBP_TX_IDLE) && enable_in && tx_valid_in &&
                         !act_reg) || load_more;
  assign tx_busy_out = (st_reg != pbp_pkg::PBP_TX_IDLE);
  assign line_out = level_reg;
  assign line_oe_out = oe_reg;
  // encoder
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    level_next = level_reg;
    oe_next = oe_reg;
    half_next = half_reg;
    bit_next = bit_reg;
    last_next = last_reg;
    unique case (st_reg)
      pbp_pkg::PBP_TX_IDLE: begin
        oe_next = 1'b0;
        if (tx_ready_out) begin
          st_next = pbp_pkg::PBP_TX_BIT;
          oe_next = 1'b1;
          level_next = 1'b0;
          bit_next = tx_bit_in;
          last_next = tx_last_in;
          half_next = 1'b0;
          cnt_next = '0;
        end
      end
      pbp_pkg::PBP_TX_BIT: begin
        if (!half_done) begin
          cnt_next = cnt_reg + 1'b1;
        end else begin
          cnt_next = '0;
          if (!half_reg) begin
            half_next = 1'b1;
            if (bit_reg) begin
              level_next = ~level_reg;
            end
          end else begin
            half_next = 1'b0;
            level_next = ~level_reg;
            if (load_more) begin
              bit_next = tx_bit_in;
              last_next = tx_last_in;
            end else begin
              st_next = pbp_pkg::PBP_TX_CLOSE;
            end
          end
        end
      end
      pbp_pkg::PBP_TX_CLOSE: begin
        // closing level held half a bit, then release
        if (!half_done) begin
          cnt_next = cnt_reg + 1'b1;
        end else begin
          cnt_next = '0;
          st_next = pbp_pkg::PBP_TX_IDLE;
          oe_next = 1'b0;
        end
      end
      default: begin
        st_next = pbp_pkg::PBP_TX_IDLE;
        oe_next = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= pbp_pkg::PBP_TX_IDLE;
      cnt_reg <= '0;
      level_reg <= pbp_pkg::LINE_RST;
      oe_reg <= 1'b0;
      half_reg <= 1'b0;
      bit_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      level_reg <= level_next;
      oe_reg <= oe_next;
      half_reg <= half_next;
      bit_reg <= bit_next;
      last_reg <= last_next;
    end
  end
  // decoder and squelch
  assign edge_seen = line_in ^ prev_reg;
  always_comb begin
    prev_next = line_in;
    ivl_next = ivl_reg;
    pend_next = pend_reg;
    rxv_next = 1'b0;
    rxb_next = rxb_reg;
    act_next = act_reg;
    if (edge_seen) begin
      ivl_next = '0;
      act_next = 1'b1;
      if (ivl_reg < pbp_pkg::SHORT_MAX) begin
        if (pend_reg) begin
          rxv_next = !tx_busy_out;
          rxb_next = 1'b1;
          pend_next = 1'b0;
        end else begin
          pend_next = 1'b1;
        end
      end else if (ivl_reg < pbp_pkg::LONG_MAX) begin
        rxv_next = !tx_busy_out;
        rxb_next = 1'b0;
        pend_next = 1'b0;
      end else begin
        // first edge after idle only synchronises
        pend_next = 1'b0;
      end
    end else if (ivl_reg != pbp_pkg::IDLE_CYC) begin
      ivl_next = ivl_reg + 1'b1;
    end else begin
      act_next = 1'b0;
      pend_next = 1'b0;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_reg <= pbp_pkg::LINE_RST;
      ivl_reg <= pbp_pkg::IDLE_CYC;
      pend_reg <= 1'b0;
      rxv_reg <= 1'b0;
      rxb_reg <= 1'b0;
      act_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      ivl_reg <= ivl_next;
      pend_reg <= pend_next;
      rxv_reg <= rxv_next;
      rxb_reg <= rxb_next;
      act_reg <= act_next;
    end
  end
  assign rx_valid_out = rxv_reg;
  assign rx_bit_out = rxb_reg;
  assign bus_active_out = act_reg;
endmodule // pbp_bmc_core

// Notes on behaviour
// - every bit starts with a level transition
// - one bits add a mid-bit transition
// - disparity stays within one bit
// - preamble begins by driving low
// - decoding survives a lost first preamble edge
// - closing edge follows the final end-of-packet bit
// - drive only while transmitting, otherwise high impedance
// - one mated pin, fixed for the connection
// - one talker; all others high impedance
// - tri-state driver: enable and level separate
// - serves only the first port's pins
// - squelch reports bus activity, own transmissions included
module pbp_device_end (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RESET_N_IN,
  // attach detection
  input wire logic CONNECTED_IN,
  input wire logic ORIENT_IN,
  // transmit bit stream
  input wire logic TX_VALID_IN,
  input wire logic TX_BIT_IN,
  input wire logic TX_LAST_IN,
  output logic TX_READY_OUT,
  output logic TX_BUSY_OUT,
  // receive bit stream
  output logic RX_VALID_OUT,
  output logic RX_BIT_OUT,
  output logic BUS_ACTIVE_OUT,
  output logic PIN_SELECT_OUT,
  // port-one cc pins
  pbp_cc_if.device CC
);
  logic conn_reg, conn_next;
  logic sel_reg, sel_next;
  logic core_line_in;
  logic core_out;
  logic core_oe;
  // orientation captured at attach, held until detach
  always_comb begin
    conn_next = CONNECTED_IN;
    sel_next = sel_reg;
    if (CONNECTED_IN && !conn_reg) begin
      sel_next = ORIENT_IN;
    end
  end
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      conn_reg <= 1'b0;
      sel_reg <= 1'b0;
    end else begin
      conn_reg <= conn_next;
      sel_reg <= sel_next;
    end
  end
  assign core_line_in = sel_reg ? CC.config_channel_pin_two : CC.config_channel_pin_one;
  assign PIN_SELECT_OUT = sel_reg;
  pbp_bmc_core u_core (
    .clk_in(CORE_CLK_IN), .rst_n_in(RESET_N_IN), .enable_in(conn_reg & CONNECTED_IN),
    .tx_valid_in(TX_VALID_IN), .tx_bit_in(TX_BIT_IN), .tx_last_in(TX_LAST_IN),
    .tx_ready_out(TX_READY_OUT), .tx_busy_out(TX_BUSY_OUT),
    .line_in(core_line_in), .line_out(core_out), .line_oe_out(core_oe),
    .rx_valid_out(RX_VALID_OUT), .rx_bit_out(RX_BIT_OUT), .bus_active_out(BUS_ACTIVE_OUT)
  );
  // only the mated pin of this port's pair is ever enabled
  assign CC.config_channel_pin_one_out = core_out;
  assign CC.config_channel_pin_two_out = core_out;
  assign CC.config_channel_pin_one_oe = core_oe & !sel_reg;
  assign CC.config_channel_pin_two_oe = core_oe & sel_reg;
endmodule // pbp_device_end

`default_nettype wire

/* pbp_partner_end.sv */
/*
  Partner end of the configuration channel: a port partner or marked cable
  controller on the single CC wire of the plug, reusing the biphase core.
  Assumes the device end file is compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module pbp_partner_end (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RESET_N_IN,
  // transmit bit stream
  input wire logic TX_VALID_IN,
  input wire logic TX_BIT_IN,
  input wire logic TX_LAST_IN,
  output logic TX_READY_OUT,
  output logic TX_BUSY_OUT,
  // receive bit stream
  output logic RX_VALID_OUT,
  output logic RX_BIT_OUT,
  output logic BUS_ACTIVE_OUT,
  // cc wire
  pbp_cc_if.partner CC
);
  // waits for squelch idle before talking, releases to high impedance after
  pbp_bmc_core u_core (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .enable_in(1'b1),
    .tx_valid_in(TX_VALID_IN),
    .tx_bit_in(TX_BIT_IN),
    .tx_last_in(TX_LAST_IN),
    .tx_ready_out(TX_READY_OUT),
    .tx_busy_out(TX_BUSY_OUT),
    .line_in(CC.partner_cc),
    .line_out(CC.partner_cc_out),
    .line_oe_out(CC.partner_cc_oe),
    .rx_valid_out(RX_VALID_OUT),
    .rx_bit_out(RX_BIT_OUT),
    .bus_active_out(BUS_ACTIVE_OUT)
  );
endmodule // pbp_partner_end

`default_nettype wire

/* pbp_cc_checker.sv */
/* Wire checker for the cc link: pin use, one talker, bmc run lengths.
   Assumes it sees the resolved drive signals of the wire interface. */
`timescale 1ns/10ps
`default_nettype none
module pbp_cc_checker (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RESET_N_IN,
  // wire signals
  input wire logic config_channel_pin_one_oe,
  input wire logic config_channel_pin_two_oe,
  input wire logic dev_on_wire_oe,
  input wire logic dev_on_wire_out,
  input wire logic partner_cc_oe,
  input wire logic partner_cc_out,
  input wire logic plug_flip
);
  default clocking @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);
  logic [8:0] run_reg;
  logic [8:0] run_next;
  logic lvl_reg;
  // legal level run lengths on the bit grid
  localparam logic [8:0] half_run = pbp_pkg::HALF_CYC;
  localparam logic [8:0] full_run = pbp_pkg::HALF_CYC << 1;
  // cycles the device has held its present level
  always_comb begin
    run_next = 9'h000;
    if (dev_on_wire_oe) begin
      run_next = (run_reg == 9'h000 || dev_on_wire_out != lvl_reg) ? 9'h001 : run_reg + 9'h001;
    end
  end
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      run_reg <= 9'h000;
      lvl_reg <= 1'b0;
    end else begin
      run_reg <= run_next;
      lvl_reg <= dev_on_wire_out;
    end
  end
  a_one_pin: assert property (!(config_channel_pin_one_oe && config_channel_pin_two_oe))
    else $error("both pins driven");
  a_mated_pin: assert property ((config_channel_pin_one_oe |-> !plug_flip) and
    (config_channel_pin_two_oe |-> plug_flip)) else $error("unmated pin driven");
  a_one_talker: assert property (!(dev_on_wire_oe && partner_cc_oe))
    else $error("two talkers");
  a_start_low: assert property ($rose(dev_on_wire_oe) |-> !dev_on_wire_out)
    else $error("device start high");
  a_partner_low: assert property ($rose(partner_cc_oe) |-> !partner_cc_out)
    else $error("partner start high");
  a_run_max: assert property (run_reg <= full_run)
    else $error("bit edge missing");
  a_run_legal: assert property (dev_on_wire_oe && $past(dev_on_wire_oe) &&
    $changed(dev_on_wire_out) |-> run_reg == half_run || run_reg == full_run)
    else $error("edge off bit grid");
  a_close_half: assert property ($fell(dev_on_wire_oe) |-> run_reg == half_run)
    else $error("closing edge length");
endmodule // pbp_cc_checker
`default_nettype wire

/* pd_cc_biphase_phy_bench.sv */
/* Bench for the cc link: device and partner ends on one wire, packets
   sent both ways. Assumes the package, interface and both ends compiled. */
`timescale 1ns/10ps
`default_nettype none
module pd_cc_biphase_phy_bench;
  logic clk, rst_n, conn, orient;
  logic [1:0] tv, tb, tl;
  wire [1:0] rdy, busy, rxv, rxb, act;
  wire psel;
  logic rq[2][$];
  int err_total;
  int num_checks;
  pbp_cc_if cc();
  pbp_device_end i_pbp_device_end (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .CONNECTED_IN(conn),
    .ORIENT_IN(orient), .TX_VALID_IN(tv[0]), .TX_BIT_IN(tb[0]), .TX_LAST_IN(tl[0]),
    .TX_READY_OUT(rdy[0]), .TX_BUSY_OUT(busy[0]), .RX_VALID_OUT(rxv[0]), .RX_BIT_OUT(rxb[0]),
    .BUS_ACTIVE_OUT(act[0]), .PIN_SELECT_OUT(psel), .CC(cc.device));
  pbp_partner_end i_pbp_partner_end (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n),
    .TX_VALID_IN(tv[1]), .TX_BIT_IN(tb[1]), .TX_LAST_IN(tl[1]), .TX_READY_OUT(rdy[1]),
    .TX_BUSY_OUT(busy[1]), .RX_VALID_OUT(rxv[1]), .RX_BIT_OUT(rxb[1]),
    .BUS_ACTIVE_OUT(act[1]), .CC(cc.partner));
  pbp_cc_checker i_pbp_cc_checker (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n),
    .config_channel_pin_one_oe(cc.config_channel_pin_one_oe),
    .config_channel_pin_two_oe(cc.config_channel_pin_two_oe),
    .dev_on_wire_oe(cc.dev_on_wire_oe), .dev_on_wire_out(cc.dev_on_wire_out),
    .partner_cc_oe(cc.partner_cc_oe), .partner_cc_out(cc.partner_cc_out),
    .plug_flip(cc.plug_flip));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) begin
    for (int e = 0; e < 2; e++) begin
      if (rxv[e] === 1'b1) rq[e].push_back(rxb[e]);
    end
  end
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // preamble then payload, lsb first; s is the sending end
  task automatic xfer(input int s, input logic [15:0] pay);
    logic [23:0] bits;
    logic [15:0] got;
    int k;
    bits = {pay, 8'hAA};
    got = 16'hXXXX;
    rq[0].delete();
    rq[1].delete();
    for (int i = 0; i < 24; i++) begin
      tv[s] = 1'b1;
      tb[s] = bits[i];
      tl[s] = (i == 23);
      #1;
      k = 0;
      while (rdy[s] !== 1'b1 && k < 300) begin
        @(negedge clk);
        k++;
      end
      @(negedge clk);
      if (i == 0) chk(busy[s] === 1'b1, "busy missing");
    end
    tv[s] = 1'b0;
    chk(act === 2'b11, "squelch quiet");
    k = 0;
    while (busy[s] !== 1'b0 && k < 300) begin
      @(negedge clk);
      k++;
    end
    chk(k < 300, "busy stuck");
    k = 0;
    while (act !== 2'b00 && k < 600) begin
      @(negedge clk);
      k++;
    end
    chk(k < 600, "squelch stuck");
    chk(rq[s].size() == 0 && rq[1-s].size() >= 16, "rx count");
    if (rq[1-s].size() >= 16) begin
      for (int i = 0; i < 16; i++) got[i] = rq[1-s][rq[1-s].size() - 16 + i];
    end
    chk(got === pay, "rx data");
  endtask
  task automatic plug(input logic f);
    conn = 1'b0;
    @(negedge clk);
    cc.plug_flip = f;
    orient = f;
    conn = 1'b1;
    repeat (2) @(negedge clk);
    chk(psel === f, "pin select");
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("[ERR] %0t watchdog", $time);
    end_of_test();
  end
  initial begin
    rst_n = 1'b0;
    {conn, orient, tv, tb, tl} = 8'h00;
    cc.plug_flip = 1'b0;
    err_total = 0;
    num_checks = 0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    plug(1'b0);
    xfer(0, 16'hC35A);
    $display("test 1 done");
    orient = 1'b1;
    @(negedge clk);
    chk(psel === 1'b0, "select moved");
    xfer(1, 16'h0FF1);
    $display("test 2 done");
    plug(1'b1);
    xfer(0, 16'h8001);
    xfer(1, 16'h7FFE);
    $display("test 3 done");
    fork
      xfer(1, 16'h1234);
      begin
        repeat (300) @(negedge clk);
        tv[0] = 1'b1;
        #1;
        chk(rdy[0] === 1'b0, "start not refused");
        @(negedge clk);
        tv[0] = 1'b0;
      end
    join
    $display("test 4 done");
    conn = 1'b0;
    @(negedge clk);
    tv[0] = 1'b1;
    #1;
    chk(rdy[0] === 1'b0, "start while detached");
    @(negedge clk);
    tv[0] = 1'b0;
    $display("test 5 done");
    end_of_test();
  end
endmodule // pd_cc_biphase_phy_bench
`default_nettype wire
